// >>> verilog/ccd_pkg.sv
/*
 Package for the call/clear/decrement execution block: opcode patterns, field positions,
 reset values, register map and bus carrier types.
 Assumes a 14-bit instruction word and a 13-bit program counter.
*/
`default_nettype none
package ccd_pkg;
	localparam int INSN_W = 14;
	localparam int PC_W = 13;
	localparam int DATA_W = 8;
	localparam int FADDR_W = 7;
	// ----------------------------------------------------------------
	// Instruction patterns
	// ----------------------------------------------------------------
	localparam logic [2:0] CALL_TOP = 3'h4;
	localparam int CALL_TOP_LSB = 11;
	localparam int IMM_W = 11;
	localparam logic [13:0] CLEAR_WORKING_OP = 14'h0103;
	localparam logic [13:0] CLEAR_WATCHDOG_OP = 14'h0064;
	localparam logic [5:0] DECREMENT_TOP = 6'h03;
	localparam int DECREMENT_TOP_LSB = 8;
	localparam int DEST_BIT = 7;
	localparam int PAGE_HI = 4;
	localparam int PAGE_LO = 3;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [7:0] ONE_BYTE = 8'h01;
	localparam logic [12:0] PC_ONE = 13'h0001;
	localparam logic [12:0] PC_RESET = 13'h0000;
	localparam logic [7:0] WORKING_RESET = 8'h00;
	localparam logic [7:0] PAGE_RESET = 8'h00;
	localparam logic [1:0] CALL_CYCLES = 2'h2;
	// ----------------------------------------------------------------
	// Register map (byte addresses, one word each)
	// ----------------------------------------------------------------
	localparam logic [5:0] REG_INSN = 6'h00;
	localparam logic [5:0] REG_FILE_IN = 6'h04;
	localparam logic [5:0] REG_PAGE = 6'h08;
	localparam logic [5:0] REG_WORKING = 6'h0c;
	localparam logic [5:0] REG_PC = 6'h10;
	localparam logic [5:0] REG_STATUS = 6'h14;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

	typedef struct packed {
		logic read;
		logic write;
		logic [5:0] address;
		logic [31:0] writedata;
	} ccd_bus_req_type;

	typedef struct packed {
		logic write;
		logic [6:0] address;
		logic [7:0] data;
	} ccd_file_wr_type;

	typedef struct packed {
		logic push;
		logic [12:0] address;
	} ccd_push_type;
endpackage
`default_nettype wire

// >>> verilog/ccd_decode.sv
/*
 Instruction classifier: turns one 14-bit word into class flags, at most one set (none for an unknown word).
 Assumes the word is stable for the cycle it is presented.
*/
`timescale 1ns/100ps
`default_nettype none
module ccd_decode (
	input wire logic [ccd_pkg::INSN_W-1:0] insn,
	output logic is_call,
	output logic is_clear_working,
	output logic is_clear_watchdog,
	output logic is_decrement
);
	import ccd_pkg::*;

	always_comb begin
		is_call = (insn[INSN_W-1:CALL_TOP_LSB] == CALL_TOP);
		is_clear_working = (insn == CLEAR_WORKING_OP);
		is_clear_watchdog = (insn == CLEAR_WATCHDOG_OP);
		is_decrement = (insn[INSN_W-1:DECREMENT_TOP_LSB] == DECREMENT_TOP);
	end
endmodule // ccd_decode
`default_nettype wire

// >>> verilog/ccd_bus.sv
/*
 Avalon-MM slave front end: answers every request in the cycle after it is seen.
 Assumes a master that holds its request until waitrequest is low.
*/
`timescale 1ns/100ps
`default_nettype none
module ccd_bus (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic avs_read,
	input wire logic avs_write,
	output logic avs_waitrequest,
	output logic accept
);
	import ccd_pkg::*;

	logic seen_r;

	// One wait cycle lets the read mux result be registered before the accepting edge.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			seen_r <= 1'b0;
		end else begin
			seen_r <= (avs_read || avs_write) && !seen_r;
		end
	end

	always_comb begin
		avs_waitrequest = (avs_read || avs_write) && !seen_r;
		accept = (avs_read || avs_write) && seen_r;
	end
endmodule // ccd_bus
`default_nettype wire

// >>> verilog/ccd_exec.sv
/*
 Execution block for four instructions: subroutine call, clear working register,
 clear watchdog and file decrement. Software loads the instruction word, the file
 operand and the page latch over Avalon-MM; writing the instruction register issues it.
 Assumes the watchdog, stack storage and file memory sit outside and take the strobes.
*/
`timescale 1ns/100ps
`default_nettype none
module ccd_exec (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [ccd_pkg::PC_W-1:0] pc,
	output ccd_pkg::ccd_push_type stack_push,
	output ccd_pkg::ccd_file_wr_type file_wr,
	output logic watchdog_clear,
	output logic busy
);
	import ccd_pkg::*;

	// ----------------------------------------------------------------
	// Execution state
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_EXEC = 3'h2,
		ST_CALL2 = 3'h4
	} ccd_state_type;

	ccd_state_type state_r, state_nxt;
	logic accept;
	logic [INSN_W-1:0] insn_r;
	logic [DATA_W-1:0] file_in_r;
	logic [DATA_W-1:0] page_r;
	logic [DATA_W-1:0] working_r;
	logic [PC_W-1:0] pc_r;
	logic zero_r;
	logic timeout_status_bit_r;
	logic powerdown_status_bit_r;
	logic is_call, is_clear_working, is_clear_watchdog, is_decrement;
	logic issue;
	logic [DATA_W-1:0] dec_result;
	logic [31:0] readdata_r;
	ccd_push_type push_r;
	ccd_file_wr_type file_wr_r;
	logic watchdog_clear_r;

	// Byte-lane merge used for every writable register.
	function automatic logic [31:0] merge_lanes(input logic [31:0] old_v,
			input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] m;
		m = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				m[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return m;
	endfunction

	// One incrementer definition serves the return address and the sequential step.
	function automatic logic [PC_W-1:0] next_pc(input logic [PC_W-1:0] p);
		return p + PC_ONE;
	endfunction

	ccd_bus u_bus (
		.mclk(mclk),
		.rstn(rstn),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_waitrequest(avs_waitrequest),
		.accept(accept)
	);

	ccd_decode u_dec (
		.insn(insn_r),
		.is_call(is_call),
		.is_clear_working(is_clear_working),
		.is_clear_watchdog(is_clear_watchdog),
		.is_decrement(is_decrement)
	);

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	// A write to the instruction register while busy is dropped so an issued
	// instruction never changes under the sequencer.
	// Writes decode the whole address, so the read-only pc and status offsets
	// cannot alias a writable register and issue a stray instruction.
	assign issue = accept && avs_write && (avs_address == REG_INSN) && (state_r == ST_IDLE);

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			insn_r <= '0;
		end else if (issue) begin
			insn_r <= INSN_W'(merge_lanes(32'(insn_r), avs_writedata, avs_byteenable));
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			file_in_r <= ZERO_BYTE;
			page_r <= PAGE_RESET;
		end else if (accept && avs_write) begin
			if (avs_address == REG_FILE_IN) begin
				file_in_r <= DATA_W'(merge_lanes(32'(file_in_r), avs_writedata, avs_byteenable));
			end
			if (avs_address == REG_PAGE) begin
				page_r <= DATA_W'(merge_lanes(32'(page_r), avs_writedata, avs_byteenable));
			end
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_comb begin
		case (state_r)
			ST_IDLE: state_nxt = issue ? ST_EXEC : ST_IDLE;
			ST_EXEC: state_nxt = is_call ? ST_CALL2 : ST_IDLE;
			ST_CALL2: state_nxt = ST_IDLE;
			default: state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign dec_result = file_in_r - ONE_BYTE;

	// ----------------------------------------------------------------
	// Program counter and stack
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pc_r <= PC_RESET;
			push_r <= '0;
		end else begin
			push_r.push <= 1'b0;
			if (state_r == ST_EXEC && is_call) begin
				push_r.push <= 1'b1;
				push_r.address <= next_pc(pc_r);
			end else if (state_r == ST_CALL2) begin
				pc_r <= {page_r[PAGE_HI:PAGE_LO], insn_r[IMM_W-1:0]};
			end else if (state_r == ST_EXEC) begin
				pc_r <= next_pc(pc_r);
			end
		end
	end

	// ----------------------------------------------------------------
	// Working register and zero flag
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			working_r <= WORKING_RESET;
			zero_r <= 1'b0;
		end else if (state_r == ST_EXEC) begin
			if (is_clear_working) begin
				working_r <= ZERO_BYTE;
				zero_r <= 1'b1;
			end else if (is_decrement) begin
				if (!insn_r[DEST_BIT]) begin
					working_r <= dec_result;
				end
				zero_r <= (dec_result == ZERO_BYTE);
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			file_wr_r <= '0;
		end else begin
			file_wr_r.write <= state_r == ST_EXEC && is_decrement && insn_r[DEST_BIT];
			file_wr_r.address <= insn_r[FADDR_W-1:0];
			file_wr_r.data <= dec_result;
		end
	end

	// ----------------------------------------------------------------
	// Watchdog clear and its status bits
	// ----------------------------------------------------------------
	// The status bits reset low here; the power-on values belong to the
	// reset logic outside, which is not part of this block.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			watchdog_clear_r <= 1'b0;
			timeout_status_bit_r <= 1'b0;
			powerdown_status_bit_r <= 1'b0;
		end else begin
			watchdog_clear_r <= state_r == ST_EXEC && is_clear_watchdog;
			if (state_r == ST_EXEC && is_clear_watchdog) begin
				timeout_status_bit_r <= 1'b1;
				powerdown_status_bit_r <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Read side
	// ----------------------------------------------------------------
	// Read data is latched in the wait cycle and stands at the accepting edge.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			readdata_r <= UNMAPPED_READ;
		end else if (avs_read && avs_waitrequest) begin
			case (avs_address)
				REG_INSN: readdata_r <= 32'(insn_r);
				REG_FILE_IN: readdata_r <= 32'(file_in_r);
				REG_PAGE: readdata_r <= 32'(page_r);
				REG_WORKING: readdata_r <= 32'(working_r);
				REG_PC: readdata_r <= 32'(pc_r);
				REG_STATUS: readdata_r <= {28'h0000000, timeout_status_bit_r,
					powerdown_status_bit_r, zero_r, busy};
				default: readdata_r <= UNMAPPED_READ;
			endcase
		end
	end

	assign avs_readdata = readdata_r;
	assign busy = (state_r != ST_IDLE);
	assign pc = pc_r;
	assign stack_push = push_r;
	assign file_wr = file_wr_r;
	assign watchdog_clear = watchdog_clear_r;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_call_push_value: assert property (@(posedge mclk) disable iff (!rstn)
		(state_r == ST_EXEC && is_call) |=> (stack_push.push && stack_push.address == $past(pc_r) + PC_ONE))
		else $error("call did not push pc plus one");
	a_call_pc_load: assert property (@(posedge mclk) disable iff (!rstn)
		(state_r == ST_CALL2) |=> (pc_r[IMM_W-1:0] == $past(insn_r[IMM_W-1:0])))
		else $error("call immediate not loaded");
	a_call_page_bits: assert property (@(posedge mclk) disable iff (!rstn)
		(state_r == ST_CALL2) |=> (pc_r[PC_W-1:IMM_W] == $past(page_r[PAGE_HI:PAGE_LO])))
		else $error("call page bits wrong");
	a_call_two_cycles: assert property (@(posedge mclk) disable iff (!rstn)
		(state_r == ST_EXEC && is_call) |=> (state_r == ST_CALL2 && $stable(zero_r)) ##1 (state_r == ST_IDLE))
		else $error("call not two cycles");
	a_clear_working: assert property (@(posedge mclk) disable iff (!rstn)
		(state_r == ST_EXEC && is_clear_working) |=> (working_r == ZERO_BYTE && zero_r && !busy))
		else $error("clear working failed");
	a_watchdog_bits: assert property (@(posedge mclk) disable iff (!rstn)
		(state_r == ST_EXEC && is_clear_watchdog) |=> (watchdog_clear && timeout_status_bit_r && powerdown_status_bit_r))
		else $error("watchdog clear failed");
	a_decrement_dest: assert property (@(posedge mclk) disable iff (!rstn)
		(state_r == ST_EXEC && is_decrement && insn_r[DEST_BIT]) |=> (file_wr.write && file_wr.data == $past(file_in_r) - ONE_BYTE && $stable(working_r)))
		else $error("decrement to file failed");
	a_decrement_zero: assert property (@(posedge mclk) disable iff (!rstn)
		(state_r == ST_EXEC && is_decrement) |=> (zero_r == ($past(file_in_r) == ONE_BYTE)))
		else $error("decrement zero flag wrong");
	a_decrement_single: assert property (@(posedge mclk) disable iff (!rstn)
		(state_r == ST_EXEC && is_decrement && !insn_r[DEST_BIT]) |=> (!busy && working_r == $past(file_in_r) - ONE_BYTE))
		else $error("decrement to working failed");
	a_push_only_call: assert property (@(posedge mclk) disable iff (!rstn)
		stack_push.push |-> ($past(state_r) == ST_EXEC && $past(is_call)))
		else $error("stack push without a call");
	a_call_status_keep: assert property (@(posedge mclk) disable iff (!rstn)
		(state_r == ST_EXEC && is_call) |=> ($stable(timeout_status_bit_r) && $stable(powerdown_status_bit_r)))
		else $error("call changed status bits");
	a_clear_working_step: assert property (@(posedge mclk) disable iff (!rstn)
		(state_r == ST_EXEC && is_clear_working) |=> (pc_r == $past(pc_r) + PC_ONE && !file_wr.write))
		else $error("clear working did not step");
	a_watchdog_pulse: assert property (@(posedge mclk) disable iff (!rstn)
		watchdog_clear |=> !watchdog_clear)
		else $error("watchdog clear longer than one cycle");
	a_watchdog_idle: assert property (@(posedge mclk) disable iff (!rstn)
		(state_r == ST_EXEC && is_clear_watchdog) |=> (!file_wr.write && !stack_push.push && $stable(working_r)))
		else $error("watchdog clear touched other state");
	a_decrement_pc: assert property (@(posedge mclk) disable iff (!rstn)
		(state_r == ST_EXEC && is_decrement) |=> (pc_r == $past(pc_r) + PC_ONE))
		else $error("decrement did not step pc");
	a_decrement_idle: assert property (@(posedge mclk) disable iff (!rstn)
		(state_r == ST_EXEC && is_decrement) |=> (!stack_push.push && !watchdog_clear))
		else $error("decrement raised a foreign strobe");
	a_file_write_only: assert property (@(posedge mclk) disable iff (!rstn)
		file_wr.write |-> ($past(state_r) == ST_EXEC && $past(is_decrement) && $past(insn_r[DEST_BIT])))
		else $error("file write without decrement to file");
endmodule // ccd_exec
`default_nettype wire

// >>> verification/test_call_clear_decrement_exec.sv
/*
 Self-checking bench for ccd_exec: drives Avalon-MM itself, issues the four instructions
 and one unknown word, and checks results at the bus and the strobe ports.
 Assumes one wait cycle per bus access and that busy covers every execution cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module test_call_clear_decrement_exec import ccd_pkg::*;;
	logic mclk, rstn, avs_read, avs_write, avs_waitrequest, watchdog_clear, busy;
	logic [5:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd, rng;
	logic [3:0] avs_byteenable;
	logic [PC_W-1:0] pc;
	ccd_push_type stack_push;
	ccd_file_wr_type file_wr;
	int mismatches, num_checks, cycles, busy_cyc, pushes, fwrites, wclears;
	logic [12:0] push_addr, pc_at_push, exp_pc, old_pc;
	logic [6:0] fw_addr, fa;
	logic [7:0] fw_data, w_exp, f, res, page;
	logic [10:0] k;
	logic z_exp, to_exp, d;

	ccd_exec i_dut (.mclk(mclk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pc(pc),
		.stack_push(stack_push), .file_wr(file_wr), .watchdog_clear(watchdog_clear), .busy(busy));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] xs();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction

	function automatic logic [31:0] status_exp();
		return {28'h0, to_exp, to_exp, z_exp, 1'b0};
	endfunction

	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// The request is held until waitrequest is sampled low; read data is taken at that edge.
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] dat,
			output logic [31:0] q);
		@(posedge mclk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= ~wr;
		avs_writedata <= dat;
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0, rd);
		check(rd, exp);
	endtask

	task automatic run_insn(input logic [13:0] w);
		busy_cyc = 0;
		pushes = 0;
		fwrites = 0;
		wclears = 0;
		bus(1'b1, 6'h00, {18'h0, w}, rd);
		@(posedge mclk);
		while (busy !== 1'b0) @(posedge mclk);
		@(posedge mclk);
		#1;
		if (w[13:11] != CALL_TOP) exp_pc = exp_pc + PC_ONE;
	endtask

	task automatic decrement(input logic [7:0] fv, input logic dd, input logic [6:0] ad);
		bus(1'b1, 6'h04, {24'h0, fv}, rd);
		run_insn({DECREMENT_TOP, dd, ad});
		res = fv - ONE_BYTE;
		z_exp = (res == ZERO_BYTE);
		if (dd) begin
			check(fwrites, 1);
			check(fw_addr, ad);
			check(fw_data, res);
		end else begin
			w_exp = res;
			check(fwrites, 0);
		end
		check(busy_cyc, 1);
		check(pushes + wclears, 0);
		rd_chk(6'h0c, {24'h0, w_exp});
		rd_chk(6'h14, status_exp());
		check(pc, exp_pc);
	endtask

	// ----------------------------------------------------------------
	// Clock, timeout and strobe monitor
	// ----------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		cycles++;
		if (cycles >= 20000) begin
			mismatches++;
			final_report();
		end
	end

	// Pulses last one cycle, so they are counted edge by edge rather than polled by the tasks.
	always @(posedge mclk) begin
		if (busy === 1'b1) busy_cyc++;
		if (stack_push.push === 1'b1) begin
			pushes++;
			push_addr = stack_push.address;
			pc_at_push = pc;
		end
		if (file_wr.write === 1'b1) begin
			fwrites++;
			fw_addr = file_wr.address;
			fw_data = file_wr.data;
		end
		if (watchdog_clear === 1'b1) wclears++;
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		rng = 32'hf843b49d;
		rstn = 1'b0;
		avs_address = 6'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
		exp_pc = PC_RESET;
		w_exp = WORKING_RESET;
		z_exp = 1'b0;
		to_exp = 1'b0;
		repeat (12) @(posedge mclk);
		rstn <= 1'b1;
		rd_chk(6'h10, 32'h0);
		rd_chk(6'h14, 32'h0);
		rd_chk(6'h0c, 32'h0);
		rd_chk(6'h20, UNMAPPED_READ);
		bus(1'b1, 6'h10, 32'h0000_1234, rd);
		rd_chk(6'h10, {19'h0, exp_pc});
		$display("test reset and map done");

		for (int i = 0; i < 24; i++) begin
			f = (i == 0) ? 8'h01 : (i == 1) ? 8'h00 : xs() & 32'hff;
			d = (i < 2) ? i[0] : xs() & 32'h1;
			fa = (i == 2) ? 7'h7f : xs() & 32'h7f;
			decrement(f, d, fa);
		end
		$display("test decrement done");

		decrement(8'h5b, 1'b0, 7'h11);
		run_insn(CLEAR_WORKING_OP);
		w_exp = ZERO_BYTE;
		z_exp = 1'b1;
		check(busy_cyc, 1);
		rd_chk(6'h0c, 32'h0);
		rd_chk(6'h14, status_exp());
		$display("test clear working done");

		run_insn(CLEAR_WATCHDOG_OP);
		to_exp = 1'b1;
		check(wclears, 1);
		check(pushes + fwrites, 0);
		rd_chk(6'h14, status_exp());
		run_insn(14'h3fff);
		check(pushes + fwrites + wclears, 0);
		check(pc, exp_pc);
		$display("test clear watchdog done");

		for (int i = 0; i < 12; i++) begin
			k = (i == 0) ? 11'h000 : (i == 1) ? 11'h7ff : xs() & 32'h7ff;
			page = (i == 0) ? 8'h18 : (i == 1) ? 8'he7 : xs() & 32'hff;
			if (i == 3) decrement(8'h01, 1'b1, 7'h05);
			bus(1'b1, 6'h08, {24'h0, page}, rd);
			old_pc = exp_pc;
			run_insn({CALL_TOP, k});
			exp_pc = {page[PAGE_HI:PAGE_LO], k};
			check(pushes, 1);
			check(push_addr, old_pc + PC_ONE);
			check(pc_at_push, old_pc);
			check(pc, exp_pc);
			check(busy_cyc, 2);
			rd_chk(6'h14, status_exp());
			rd_chk(6'h10, {19'h0, exp_pc});
		end
		$display("test call done");
		final_report();
	end
endmodule // test_call_clear_decrement_exec
`default_nettype wire
